// ### inc/gpec_params.svh
// Purpose: Offsets, field positions and reset values of the event counter.
// Assumes: Byte offsets on a 32-bit AHB-Lite register bus.
// Notes:   Included by the top module and the test bench.
`ifndef GPEC_PARAMS_SVH
`define GPEC_PARAMS_SVH

`define GPEC_OFS_CTRL   8'h00
`define GPEC_OFS_INIT   8'h04
`define GPEC_OFS_DELAY  8'h08
`define GPEC_OFS_WIDTH  8'h0c
`define GPEC_OFS_COUNT  8'h10
`define GPEC_OFS_CAPT   8'h14
`define GPEC_OFS_STAT   8'h18

`define GPEC_CTRL_W     11
`define GPEC_CTRL_RST   11'h008
`define GPEC_CTRL_ARM   0
`define GPEC_CTRL_PULSE 1
`define GPEC_CTRL_DIRHW 2
`define GPEC_CTRL_DIRUP 3
`define GPEC_CTRL_GFN   5:4
`define GPEC_CTRL_START 6
`define GPEC_CTRL_RETRG 7
`define GPEC_CTRL_BUF   8
`define GPEC_CTRL_SPOL  9
`define GPEC_CTRL_GPOL  10

`define GPEC_GFN_NONE   2'h0
`define GPEC_GFN_IVAL   2'h1
`define GPEC_GFN_CAPT   2'h2

`define GPEC_STAT_ARMED 0
`define GPEC_STAT_RUN   1
`define GPEC_STAT_OPEN  2
`define GPEC_STAT_PULSE 3
`define GPEC_STAT_FREE  4
`define GPEC_STAT_OVR   5

`endif

// ### inc/gpec_pkg.sv
// Purpose: Types shared by the event counter modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Numbers live in gpec_params.svh.
package gpec_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_DELAY,
        PH_HIGH,
        PH_DONE
    } gpec_phase_e;
endpackage

// ### inc/gpec_stream_if.sv
// Purpose: Valid/ready word stream between counter core and buffer.
// Assumes: One clock for both ends.
// Notes:   A word moves on an edge where valid and ready are both high.
`timescale 1ns/100ps
interface gpec_stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### hdl/gpec_edge.sv
// Purpose: Active-edge detector with selectable polarity.
// Assumes: Input is synchronous to hclk.
// Notes:   Pulse is one cycle, in the cycle the new level is seen.
`timescale 1ns/100ps
module gpec_edge (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // Signal
    input  wire logic din,
    input  wire logic fall_sel,
    output logic      edge_pulse
);
    typedef struct packed {
        logic prev;
    } gpec_edge_s;

    gpec_edge_s s;
    gpec_edge_s next_s;

    always_comb begin
        next_s = s;
        next_s.prev = din;
    end

    // Rising edge by default, falling when selected.
    assign edge_pulse = fall_sel ? (s.prev & ~din) : (~s.prev & din);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule

// ### hdl/gpec_fifo.sv
// Purpose: Small shift buffer for captured measurements.
// Assumes: Head entry drives the output directly.
// Notes:   Ready on the fill side is low whenever the last slot is used.
`timescale 1ns/100ps
module gpec_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // Fill side
    gpec_stream_if.snk in_s,
    // Drain side
    output logic          out_valid,
    input  wire logic     out_ready,
    output logic [W-1:0]  out_data
);
    typedef struct packed {
        logic [DEPTH-1:0]        vld;
        logic [DEPTH-1:0][W-1:0] mem;
    } gpec_fifo_s;

    gpec_fifo_s s;
    gpec_fifo_s next_s;
    logic [DEPTH:0]        vx;
    logic [DEPTH:0][W-1:0] mx;
    logic                  pop;
    logic                  push;

    if (DEPTH < 2) begin : g_chk
        $error("gpec_fifo needs DEPTH of at least 2");
    end

    assign in_s.ready = ~s.vld[DEPTH-1];
    assign out_valid  = s.vld[0];
    assign out_data   = s.mem[0];
    assign pop        = s.vld[0] & out_ready;
    assign push       = in_s.valid & ~s.vld[DEPTH-1];
    assign vx         = {1'b0, s.vld};
    assign mx         = {{W{1'b0}}, s.mem};

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic         sv;
        logic [W-1:0] sd;
        logic         lower;
        assign sv    = pop ? vx[i+1] : vx[i];
        assign sd    = pop ? mx[i+1] : mx[i];
        if (i == 0) begin : g_first
            assign lower = 1'b1;
        end else begin : g_rest
            assign lower = pop ? vx[i] : vx[i-1];
        end
        always_comb begin
            next_s.vld[i] = sv;
            next_s.mem[i] = sd;
            if (push && !sv && lower) begin
                next_s.vld[i] = 1'b1;
                next_s.mem[i] = in_s.data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule

// ### hdl/gpec_top.sv
// Purpose: General-purpose event counter and pulse timer on AHB-Lite.
// Assumes: All pins synchronous to hclk; hready comes back from hreadyout.
// Notes:   Zero wait states; one register per aligned word.
// Function
// - Counter has count-edge, control-edge, result output and direction.
// - Each active count edge moves the count by one, up or down.
// - Control edge bounds counting intervals or captures the count.
// - Hardware direction counts up while direction is high, else down.
// - Pulses are timed in whole periods of the count-edge input.
// - Control edge triggers one pulse, or a pulse after every edge; here an edge that comes before the last pulse has ended is ignored.
// - Buffered mode measures continuously, capturing on each control edge.
// - Buffered results leave as a sequential stream for the host.
// - Unbuffered results appear on the result output at each control edge.
// - With a start trigger, counting waits for it; else starts on arming.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "gpec_params.svh"
module gpec_top
    import gpec_pkg::*;
#(
    parameter int CW    = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          ce,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    // AHB-Lite answer
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // Counter pins
    input  wire logic          cnt_edge_in,
    input  wire logic          ctl_edge_in,
    input  wire logic          dir_in,
    // Counter results
    output logic               out_pulse,
    output logic [CW-1:0]      result_value,
    output logic               result_valid,
    // Measurement stream
    output logic               strm_valid,
    input  wire logic          strm_ready,
    output logic [CW-1:0]      strm_data
);
    typedef struct packed {
        logic                    hready;
        logic [31:0]             hrdata;
        logic                    resp;
        logic                    wr_pend;
        logic [7:0]              wr_addr;
        logic [`GPEC_CTRL_W-1:0] ctrl;
        logic [CW-1:0]           init;
        logic [CW-1:0]           delay;
        logic [CW-1:0]           width;
        logic [CW-1:0]           count;
        logic [CW-1:0]           capt;
        logic [CW-1:0]           tmr;
        logic                    armed;
        logic                    running;
        logic                    gate_open;
        logic                    pulse;
        gpec_phase_e             phase;
        logic [CW-1:0]           res_val;
        logic                    res_vld;
        logic                    push;
        logic [CW-1:0]           push_data;
        logic                    overrun;
    } gpec_top_s;

    gpec_top_s s;
    gpec_top_s next_s;
    logic      src_edge;
    logic      gate_edge;
    logic      fifo_free;

    gpec_stream_if #(.W(CW)) fill ();

    if (CW < 16 || CW > 32) begin : g_chk
        $error("gpec_top supports CW from 16 to 32");
    end

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    gpec_edge u_src (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .din        (cnt_edge_in),
        .fall_sel   (s.ctrl[`GPEC_CTRL_SPOL]),
        .edge_pulse (src_edge)
    );

    gpec_edge u_gate (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .din        (ctl_edge_in),
        .fall_sel   (s.ctrl[`GPEC_CTRL_GPOL]),
        .edge_pulse (gate_edge)
    );

    gpec_fifo #(
        .W     (CW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .in_s      (fill.snk),
        .out_valid (strm_valid),
        .out_ready (strm_ready),
        .out_data  (strm_data)
    );

    assign fill.valid = s.push;
    assign fill.data  = s.push_data;
    assign fifo_free  = fill.ready;

    always_comb begin
        logic          up;
        logic          take;
        logic [CW-1:0] meas;
        logic [1:0]    gfn;
        up     = 1'b0;
        take   = 1'b0;
        meas   = s.count;
        gfn    = s.ctrl[`GPEC_CTRL_GFN];

        next_s = s;
        next_s.hready  = 1'b1;
        next_s.resp    = 1'b0;
        next_s.res_vld = 1'b0;

        if (s.push && fifo_free) begin
            next_s.push = 1'b0;
        end

        // Event counting.
        if (s.ctrl[`GPEC_CTRL_DIRHW]) begin
            up = dir_in;
        end else begin
            up = s.ctrl[`GPEC_CTRL_DIRUP];
        end

        if (s.armed && !s.ctrl[`GPEC_CTRL_PULSE]) begin
            if (gate_edge) begin
                if (!s.running) begin
                    next_s.running = 1'b1;
                end else if (gfn == `GPEC_GFN_IVAL) begin
                    next_s.gate_open = ~s.gate_open;
                    take = s.gate_open;
                end else if (gfn == `GPEC_GFN_CAPT) begin
                    take = 1'b1;
                end
            end

            if (src_edge && s.running &&
                (gfn != `GPEC_GFN_IVAL || s.gate_open)) begin
                if (up) begin
                    next_s.count = s.count + 1'b1;
                end else begin
                    next_s.count = s.count - 1'b1;
                end
            end
        end

        // Result delivery, buffered or direct.
        if (take) begin
            next_s.capt = meas;

            if (s.ctrl[`GPEC_CTRL_BUF]) begin
                if (s.push && !fifo_free) begin
                    next_s.overrun = 1'b1;
                end else begin
                    next_s.push      = 1'b1;
                    next_s.push_data = meas;
                end
            end else begin
                next_s.res_val = meas;
                next_s.res_vld = 1'b1;
            end
        end

        // Pulse generation.
        if (s.armed && s.ctrl[`GPEC_CTRL_PULSE]) begin
            unique case (s.phase)
                PH_IDLE: begin
                    if (s.running ||
                        (gate_edge && s.ctrl[`GPEC_CTRL_START])) begin
                        next_s.running = 1'b1;
                        next_s.phase   = PH_DELAY;
                        next_s.tmr     = s.delay;
                    end
                end

                PH_DELAY: begin
                    if (src_edge) begin
                        if (s.tmr <= CW'(1)) begin
                            next_s.phase = PH_HIGH;
                            next_s.pulse = 1'b1;
                            next_s.tmr   = s.width;
                        end else begin
                            next_s.tmr = s.tmr - 1'b1;
                        end
                    end
                end

                PH_HIGH: begin
                    if (src_edge) begin
                        if (s.tmr <= CW'(1)) begin
                            next_s.phase = PH_DONE;
                            next_s.pulse = 1'b0;
                        end else begin
                            next_s.tmr = s.tmr - 1'b1;
                        end
                    end
                end

                PH_DONE: begin
                    if (gate_edge && s.ctrl[`GPEC_CTRL_START] &&
                        s.ctrl[`GPEC_CTRL_RETRG]) begin
                        next_s.phase = PH_DELAY;
                        next_s.tmr   = s.delay;
                    end
                end
            endcase
        end

        // Register writes, data phase.
        if (s.wr_pend) begin
            if (hit(s.wr_addr, `GPEC_OFS_CTRL)) begin
                next_s.ctrl = hwdata[`GPEC_CTRL_W-1:0];

                if (hwdata[`GPEC_CTRL_ARM] &&
                    !s.ctrl[`GPEC_CTRL_ARM]) begin
                    next_s.armed     = 1'b1;
                    next_s.count     = s.init;
                    next_s.running   = ~hwdata[`GPEC_CTRL_START];
                    next_s.gate_open = 1'b0;
                    next_s.phase     = PH_IDLE;
                    next_s.pulse     = 1'b0;
                end else if (!hwdata[`GPEC_CTRL_ARM]) begin
                    next_s.armed   = 1'b0;
                    next_s.running = 1'b0;
                    next_s.phase   = PH_IDLE;
                    next_s.pulse   = 1'b0;
                end
            end

            if (hit(s.wr_addr, `GPEC_OFS_INIT)) begin
                next_s.init = hwdata[CW-1:0];
            end

            if (hit(s.wr_addr, `GPEC_OFS_DELAY)) begin
                next_s.delay = hwdata[CW-1:0];
            end

            if (hit(s.wr_addr, `GPEC_OFS_WIDTH)) begin
                next_s.width = hwdata[CW-1:0];
            end

            if (hit(s.wr_addr, `GPEC_OFS_STAT) &&
                hwdata[`GPEC_STAT_OVR] && !next_s.overrun) begin
                next_s.overrun = 1'b0;
            end

            if (hit(s.wr_addr, `GPEC_OFS_STAT) &&
                hwdata[`GPEC_STAT_OVR] &&
                !(take && s.push && !fifo_free)) begin
                next_s.overrun = 1'b0;
            end
        end

        // Address phase.
        next_s.wr_pend = hsel && htrans[1] && hready && hwrite;
        next_s.wr_addr = haddr[7:0];

        if (hsel && htrans[1] && hready && !hwrite) begin
            next_s.hrdata = 32'h0000_0000;

            if (hit(haddr[7:0], `GPEC_OFS_CTRL)) begin
                next_s.hrdata = 32'(s.ctrl);
            end

            if (hit(haddr[7:0], `GPEC_OFS_INIT)) begin
                next_s.hrdata = 32'(s.init);
            end

            if (hit(haddr[7:0], `GPEC_OFS_DELAY)) begin
                next_s.hrdata = 32'(s.delay);
            end

            if (hit(haddr[7:0], `GPEC_OFS_WIDTH)) begin
                next_s.hrdata = 32'(s.width);
            end

            if (hit(haddr[7:0], `GPEC_OFS_COUNT)) begin
                next_s.hrdata = 32'(s.count);
            end

            if (hit(haddr[7:0], `GPEC_OFS_CAPT)) begin
                next_s.hrdata = 32'(s.capt);
            end

            if (hit(haddr[7:0], `GPEC_OFS_STAT)) begin
                next_s.hrdata[`GPEC_STAT_ARMED] = s.armed;
                next_s.hrdata[`GPEC_STAT_RUN]   = s.running;
                next_s.hrdata[`GPEC_STAT_OPEN]  = s.gate_open;
                next_s.hrdata[`GPEC_STAT_PULSE] = s.pulse;
                next_s.hrdata[`GPEC_STAT_FREE]  = fifo_free;
                next_s.hrdata[`GPEC_STAT_OVR]   = s.overrun;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s        <= '0;
            s.ctrl   <= `GPEC_CTRL_RST;
            s.hready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs of the counter core.
    assign hreadyout    = s.hready;
    assign hresp        = s.resp;
    assign hrdata       = s.hrdata;
    assign out_pulse    = s.pulse;
    assign result_value = s.res_val;
    assign result_valid = s.res_vld;
endmodule

// ### dv/gpec_top_assertions.sv
// Purpose: Concurrent checks on the event counter's top-level ports.
// Assumes: One clock domain; hresetn low clears every output but hreadyout, which it sets.
// Notes:   Bound into gpec_top at the foot of this file.
`timescale 1ns/100ps
module gpec_top_assertions #(
    parameter int CW    = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // Bus
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic [31:0]   hrdata,
    // Counter pins and stream
    input wire logic          cnt_edge_in,
    input wire logic          ctl_edge_in,
    input wire logic          out_pulse,
    input wire logic [CW-1:0] result_value,
    input wire logic          result_valid,
    input wire logic          strm_valid,
    input wire logic          strm_ready,
    input wire logic [CW-1:0] strm_data
);
    logic       gate_q;
    logic       src_q;
    logic [3:0] gate_age;
    logic [3:0] src_age;

    // Cycles since each edge input last changed, saturating.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_q   <= 1'b0;
            src_q    <= 1'b0;
            gate_age <= 4'hf;
            src_age  <= 4'hf;
        end else begin
            gate_q   <= ctl_edge_in;
            src_q    <= cnt_edge_in;
            gate_age <= (ctl_edge_in != gate_q) ? 4'h0 :
                        (gate_age == 4'hf) ? gate_age : gate_age + 4'h1;
            src_age  <= (cnt_edge_in != src_q) ? 4'h0 :
                        (src_age == 4'hf) ? src_age : src_age + 4'h1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_stalled;
        strm_valid && !strm_ready;
    endsequence
    sequence s_held;
        strm_valid && $stable(strm_data);
    endsequence
    property p_stall_hold;
        s_stalled |=> s_held;
    endproperty

    a_zero_wait: assert property (hreadyout)
        else $error("hreadyout low outside reset");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not OKAY");
    a_rdata_hold: assert property (
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result_valid longer than one cycle");
    a_result_hold: assert property ($changed(result_value) |-> result_valid)
        else $error("result_value changed without result_valid");
    a_result_gate: assert property (result_valid |-> gate_age <= 4'h4)
        else $error("result without a recent gate edge");
    a_pulse_source: assert property ($changed(out_pulse) |-> src_age <= 4'h4)
        else $error("out_pulse moved without a count edge");
    a_stall_hold: assert property (p_stall_hold)
        else $error("stream word lost or changed while stalled");
endmodule

bind gpec_top gpec_top_assertions #(.CW(CW), .DEPTH(DEPTH)) chk_u (.*);

// ### dv/gpec_far_end.sv
// Purpose: External signal sources and host drain for the event counter.
// Assumes: Caller is just past a rising edge when a task starts.
// Notes:   Stall holds the drain off so the buffer fills.
`timescale 1ns/100ps
module gpec_far_end #(
    parameter int CW = 32
) (
    // Clock
    input  wire logic          hclk,
    // Signal pins
    output logic               cnt_edge_in,
    output logic               ctl_edge_in,
    output logic               dir_in,
    // Stream drain
    input  wire logic          strm_valid,
    input  wire logic [CW-1:0] strm_data,
    output logic               strm_ready
);
    logic          stall;
    logic [CW-1:0] words[$];

    initial begin
        cnt_edge_in = 1'b0;
        ctl_edge_in = 1'b0;
        dir_in      = 1'b1;
        strm_ready  = 1'b0;
        stall       = 1'b1;
    end

    // The host engine takes a word on each edge where valid meets ready.
    always @(posedge hclk) begin
        if (strm_valid === 1'b1 && strm_ready === 1'b1) begin
            words.push_back(strm_data);
        end
        strm_ready <= !stall;
    end

    // Each level is held two edges so that a low and a high are sampled.
    task automatic set_cnt(input logic v);
        cnt_edge_in <= v;
        repeat (2) @(posedge hclk);
    endtask

    task automatic set_gate(input logic v);
        ctl_edge_in <= v;
        repeat (2) @(posedge hclk);
    endtask

    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            set_cnt(1'b1);
            set_cnt(1'b0);
        end
    endtask
endmodule

// ### dv/gpec_top_test.sv
// Purpose: Self-checking bench for the event counter.
// Assumes: Zero-wait AHB-Lite slave; ce dropped only while bus is idle.
// Notes:   Results of unbuffered captures are logged by a monitor.
`timescale 1ns/100ps
`include "gpec_params.svh"
module gpec_top_test;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, result_value, strm_data, last_res;
    logic        cnt_edge_in, ctl_edge_in, dir_in, out_pulse, ce;
    logic        result_valid, strm_valid, strm_ready;
    int          fail_count = 0;
    int          checked = 0;
    int          n_res = 0;

    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    gpec_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cnt_edge_in(cnt_edge_in),
        .ctl_edge_in(ctl_edge_in), .dir_in(dir_in), .out_pulse(out_pulse),
        .result_value(result_value), .result_valid(result_valid),
        .strm_valid(strm_valid), .strm_ready(strm_ready),
        .strm_data(strm_data)
    );

    gpec_far_end far_u (
        .hclk(hclk), .cnt_edge_in(cnt_edge_in), .ctl_edge_in(ctl_edge_in),
        .dir_in(dir_in), .strm_valid(strm_valid), .strm_data(strm_data),
        .strm_ready(strm_ready)
    );

    always @(posedge hclk) begin
        if (result_valid === 1'b1) begin
            n_res    <= n_res + 1;
            last_res <= result_value;
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                final_report;
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e, input logic [31:0] m = '1);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r & m);
    endtask

    task automatic arm(input logic [31:0] init, input logic [31:0] ctrl);
        wr(`GPEC_OFS_INIT, init);
        wr(`GPEC_OFS_CTRL, 32'h0);
        wr(`GPEC_OFS_CTRL, ctrl);
    endtask

    task automatic gate_pulse;
        far_u.set_gate(1'b1);
        far_u.set_gate(1'b0);
        @(posedge hclk);
    endtask

    task automatic pulse_pat(input string nm, input logic [4:0] pat);
        for (int i = 0; i < 5; i++) begin
            far_u.pulses(1);
            chk(nm, {31'h0, pat[4-i]}, {31'h0, out_pulse});
        end
    endtask

    task automatic t_regs;
        rdc("ctrl reset", `GPEC_OFS_CTRL, 32'h8);
        wr(8'h1c, 32'hffffffff);
        rdc("unmapped", 8'h1c, 32'h0);
        wr(`GPEC_OFS_COUNT, 32'h5);
        rdc("count ro", `GPEC_OFS_COUNT, 32'h0);
    endtask

    task automatic t_count;
        arm(32'h5, 32'h9);
        far_u.pulses(3);
        rdc("count up", `GPEC_OFS_COUNT, 32'h8);
        wr(`GPEC_OFS_CTRL, 32'h5);
        far_u.dir_in <= 1'b0;
        far_u.pulses(2);
        rdc("count hw down", `GPEC_OFS_COUNT, 32'h6);
        far_u.dir_in <= 1'b1;
        far_u.pulses(1);
        rdc("count hw up", `GPEC_OFS_COUNT, 32'h7);
        ce <= 1'b0;
        far_u.pulses(2);
        ce <= 1'b1;
        rdc("count frozen", `GPEC_OFS_COUNT, 32'h7);
        wr(`GPEC_OFS_CTRL, 32'h0);
        far_u.pulses(2);
        rdc("count disarmed", `GPEC_OFS_COUNT, 32'h7);
        arm(32'h5, 32'h209);
        far_u.set_cnt(1'b1);
        rdc("fall sel rise", `GPEC_OFS_COUNT, 32'h5);
        far_u.set_cnt(1'b0);
        rdc("fall sel fall", `GPEC_OFS_COUNT, 32'h6);
    endtask

    task automatic t_start;
        arm(32'h0, 32'h49);
        far_u.pulses(2);
        rdc("held off", `GPEC_OFS_COUNT, 32'h0);
        gate_pulse;
        far_u.pulses(1);
        rdc("started", `GPEC_OFS_COUNT, 32'h1);
    endtask

    task automatic t_capture;
        arm(32'h10, 32'h29);
        far_u.pulses(2);
        gate_pulse;
        chk("capture value", 32'h12, last_res);
        arm(32'h10, 32'h429);
        gate_pulse;
        chk("capture count", 32'h2, n_res);
        chk("capture fall", 32'h10, last_res);
        rdc("capt reg", `GPEC_OFS_CAPT, 32'h10);
        arm(32'h0, 32'h19);
        far_u.pulses(1);
        gate_pulse;
        far_u.pulses(2);
        gate_pulse;
        chk("interval", 32'h2, last_res);
    endtask

    task automatic t_buffered;
        arm(32'h0, 32'h129);
        for (int k = 0; k < 4; k++) begin
            far_u.pulses(1);
            gate_pulse;
        end
        rdc("overrun", `GPEC_OFS_STAT, 32'h20, 32'h20);
        chk("no unbuffered", 32'h3, n_res);
        far_u.stall <= 1'b0;
        repeat (10) @(posedge hclk);
        chk("word 0", 32'h1, far_u.words[0]);
        chk("word 1", 32'h2, far_u.words[1]);
        chk("drained", 32'h0, {31'h0, strm_valid});
        wr(`GPEC_OFS_STAT, 32'h20);
        rdc("ovr clear", `GPEC_OFS_STAT, 32'h10, 32'h30);
    endtask

    task automatic t_pulse;
        wr(`GPEC_OFS_DELAY, 32'h2);
        wr(`GPEC_OFS_WIDTH, 32'h3);
        arm(32'h0, 32'hb);
        @(posedge hclk);
        pulse_pat("pulse on arm", 5'b01110);
        arm(32'h0, 32'hcb);
        gate_pulse;
        pulse_pat("retrig first", 5'b01110);
        gate_pulse;
        pulse_pat("retrig again", 5'b01110);
        arm(32'h0, 32'h4b);
        gate_pulse;
        pulse_pat("single first", 5'b01110);
        gate_pulse;
        pulse_pat("single again", 5'b00000);
    endtask

    initial begin
        hresetn = 1'b0;
        ce      = 1'b1;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hwdata  = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_count;
        t_start;
        t_capture;
        t_buffered;
        t_pulse;
        final_report;
    end
endmodule
